// ==== mpc_config_regs.sv ====
/*
 * monitor gain and playback-only control register bank behind an axi4-lite
 * slave. registers are byte wide in the low lane of aligned words.
 * assumes one clock, synchronous active-low reset, a well-behaved master.
 */
`timescale 1ns/1ps
`include "mpc_params.svh"

// Notes on behaviour
// - left monitor gain 7 bits, reset 1010111
// - codes 0..62 give 0.5 dB steps
// - code 1010111 mutes when attenuation enabled
// - code 1111111 mutes when attenuation disabled
// - right monitor gain, same coding and reset
// - mode enable bit, reset 1, gates mode
// - line input mute bit, reset 0
// - left opamp on bit, reset 0
// - right opamp on bit, reset 0
// - headphone amp on, else bypass switch on
// - charge pump auto bypass enable, reset 0
// - mic regulator enable, reset 1
// - pump enable, clearing it forces bypass
// - preamp enable bit, reset 0
// - headphone source select, reset 11, avoid 10
module mpc_config_regs
    import mpc_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address channel
    input wire logic awvalid,
    output logic awready,
    input wire logic [`MPC_ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // write data channel
    input wire logic wvalid,
    output logic wready,
    input wire logic [`MPC_DATA_W-1:0] wdata,
    input wire logic [3:0] wstrb,
    // write response channel
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // read address channel
    input wire logic arvalid,
    output logic arready,
    input wire logic [`MPC_ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // read data channel
    output logic rvalid,
    input wire logic rready,
    output logic [`MPC_DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    // analog side
    input wire logic negative_attenuation_enable,
    output mpc_gain_t monitor_left_gain,
    output mpc_gain_t monitor_right_gain,
    output mpc_pbo_ctrl_t playback_ctrl
);

    // maps a byte address to {hit, register slot}; used by read and write
    function automatic logic [2:0] mpc_decode(input logic [`MPC_ADDR_W-1:0] addr);
        logic [5:0] idx;
        idx = addr[`MPC_ADDR_W-1:2];
        if (addr[1:0] != 2'b00) begin
            mpc_decode = 3'b000;
        end else if (idx >= `MPC_IDX_FIRST && idx <= `MPC_IDX_LAST) begin
            mpc_decode = {1'b1, 2'(idx - `MPC_IDX_FIRST)};
        end else begin
            mpc_decode = 3'b000;
        end
    endfunction : mpc_decode

    // reset values and writable masks per slot
    localparam logic [`MPC_REG_W-1:0] RST_VAL [`MPC_NUM_REGS] = '{
        `MPC_RST_GAIN, `MPC_RST_GAIN, `MPC_RST_PBO_A, `MPC_RST_PBO_B};
    localparam logic [`MPC_REG_W-1:0] WR_MASK [`MPC_NUM_REGS] = '{
        `MPC_MASK_GAIN, `MPC_MASK_GAIN, `MPC_MASK_PBO_A, `MPC_MASK_PBO_B};
    localparam int SLOT_PBO_B = 3;

    // register storage, indexed by slot
    logic [`MPC_REG_W-1:0] regs_reg [`MPC_NUM_REGS];
    logic [`MPC_REG_W-1:0] regs_next [`MPC_NUM_REGS];

    // write channel state and held address/data
    mpc_wr_state_t wr_state_reg;
    mpc_wr_state_t wr_state_next;
    logic [`MPC_ADDR_W-1:0] awaddr_reg; // address taken before data
    logic [`MPC_DATA_W-1:0] wdata_reg;  // data taken before address
    logic [3:0] wstrb_reg;
    logic [1:0] bresp_reg;

    // read channel
    logic rvalid_reg;
    logic [`MPC_DATA_W-1:0] rdata_reg;
    logic [1:0] rresp_reg;

    // registered analog controls
    mpc_gain_t left_gain_reg;
    mpc_gain_t right_gain_reg;
    mpc_pbo_ctrl_t ctrl_reg;

    // handshake decode
    assign awready = (wr_state_reg == MPC_WR_IDLE) || (wr_state_reg == MPC_WR_DATA);
    assign wready = (wr_state_reg == MPC_WR_IDLE) || (wr_state_reg == MPC_WR_ADDR);
    wire aw_fire = awvalid && awready;
    wire w_fire = wvalid && wready;

    // both halves present this cycle, live or held
    wire wr_commit = (wr_state_reg == MPC_WR_IDLE && aw_fire && w_fire)
                   || (wr_state_reg == MPC_WR_ADDR && w_fire)
                   || (wr_state_reg == MPC_WR_DATA && aw_fire);
    wire [`MPC_ADDR_W-1:0] wr_addr_eff = (wr_state_reg == MPC_WR_ADDR) ? awaddr_reg : awaddr;
    wire [`MPC_DATA_W-1:0] wr_data_eff = (wr_state_reg == MPC_WR_DATA) ? wdata_reg : wdata;
    wire [3:0] wr_strb_eff = (wr_state_reg == MPC_WR_DATA) ? wstrb_reg : wstrb;
    wire [2:0] wr_dec = mpc_decode(wr_addr_eff);
    wire wr_hit = wr_dec[2];
    wire [1:0] wr_slot = wr_dec[1:0];
    // only lane 0 holds register bits; other lanes are accepted and dropped
    wire wr_lane0 = wr_strb_eff[0];

    // write channel next state
    always_comb begin
        wr_state_next = wr_state_reg;
        case (wr_state_reg)
            MPC_WR_IDLE: begin
                if (aw_fire && w_fire) begin
                    wr_state_next = MPC_WR_RESP;
                end else if (aw_fire) begin
                    wr_state_next = MPC_WR_ADDR;
                end else if (w_fire) begin
                    wr_state_next = MPC_WR_DATA;
                end
            end
            MPC_WR_ADDR: begin
                if (w_fire) begin
                    wr_state_next = MPC_WR_RESP;
                end
            end
            MPC_WR_DATA: begin
                if (aw_fire) begin
                    wr_state_next = MPC_WR_RESP;
                end
            end
            default: begin
                if (bready) begin
                    wr_state_next = MPC_WR_IDLE;
                end
            end
        endcase
    end

    // per-register next value: masked bits replaced, undefined bits forced low
    genvar gi;
    generate
        for (gi = 0; gi < `MPC_NUM_REGS; gi++) begin : g_reg
            wire sel = wr_commit && wr_hit && wr_lane0 && (wr_slot == 2'(gi));
            wire [`MPC_REG_W-1:0] merged = wr_data_eff[`MPC_REG_W-1:0] & WR_MASK[gi];
            if (gi == SLOT_PBO_B) begin : g_src
                // the reserved source code would route nothing sane; keep the old source
                wire src_bad = (merged[`MPC_B_SRC_HI:`MPC_B_SRC_LO] == `MPC_SRC_RESERVED);
                wire [`MPC_REG_W-1:0] guarded = src_bad
                    ? {merged[`MPC_REG_W-1:2], regs_reg[gi][`MPC_B_SRC_HI:`MPC_B_SRC_LO]}
                    : merged;
                assign regs_next[gi] = sel ? guarded : regs_reg[gi];
            end else begin : g_plain
                assign regs_next[gi] = sel ? merged : regs_reg[gi];
            end

            // storage with documented reset values
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    regs_reg[gi] <= RST_VAL[gi];
                end else begin
                    regs_reg[gi] <= regs_next[gi];
                end
            end
        end
    endgenerate

    // write channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_reg <= MPC_WR_IDLE;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            bresp_reg <= `MPC_RESP_OKAY;
        end else begin
            wr_state_reg <= wr_state_next;
            if (aw_fire) begin
                awaddr_reg <= awaddr;
            end
            if (w_fire) begin
                wdata_reg <= wdata;
                wstrb_reg <= wstrb;
            end
            if (wr_commit) begin
                bresp_reg <= wr_hit ? `MPC_RESP_OKAY : `MPC_RESP_SLVERR;
            end
        end
    end

    assign bvalid = (wr_state_reg == MPC_WR_RESP);
    assign bresp = bresp_reg;

    // read decode; one read outstanding, address refused while data waits
    assign arready = !rvalid_reg;
    wire ar_fire = arvalid && arready;
    wire [2:0] rd_dec = mpc_decode(araddr);
    wire [`MPC_DATA_W-1:0] rd_word = rd_dec[2]
        ? {{(`MPC_DATA_W-`MPC_REG_W){1'b0}}, regs_reg[rd_dec[1:0]]}
        : '0;

    // read channel registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= `MPC_RESP_OKAY;
        end else if (ar_fire) begin
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= rd_dec[2] ? `MPC_RESP_OKAY : `MPC_RESP_SLVERR;
        end else if (rready) begin
            rvalid_reg <= 1'b0;
        end
    end

    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    // gain decoders for both monitor channels
    mpc_gain_t gain_dec [2];
    generate
        for (gi = 0; gi < 2; gi++) begin : g_gain
            mpc_gain_decode u_dec (
                .gain_code(regs_reg[gi][6:0]),
                .negative_attenuation_enable(negative_attenuation_enable),
                .gain(gain_dec[gi])
            );
        end
    endgenerate

    // playback-only controls, gated by the mode enable except pump, pump auto bypass and source select
    wire mode_on = regs_reg[2][`MPC_A_ENABLE];
    wire hph_on = mode_on && regs_reg[3][`MPC_B_HPH_ON];
    wire pump_on = regs_reg[3][`MPC_B_PUMP_ON];
    mpc_pbo_ctrl_t ctrl_next;
    always_comb begin
        ctrl_next.mode_enable = mode_on;
        ctrl_next.line_input_mute = mode_on && regs_reg[2][`MPC_A_LINE_MUTE];
        ctrl_next.opamp_left_on = mode_on && regs_reg[2][`MPC_A_OPAMP_L];
        ctrl_next.opamp_right_on = mode_on && regs_reg[2][`MPC_A_OPAMP_R];
        ctrl_next.headphone_amp_on = hph_on;
        // amp off or pump off both close the music bypass
        ctrl_next.bypass_switch_on = !hph_on || !pump_on;
        ctrl_next.pump_auto_bypass_enable = regs_reg[3][`MPC_B_PUMP_BYP];
        ctrl_next.mic_regulator_on = mode_on && regs_reg[3][`MPC_B_REG_ON];
        ctrl_next.mic_pump_on = pump_on;
        ctrl_next.preamp_on = mode_on && regs_reg[3][`MPC_B_PREAMP_ON];
        ctrl_next.source_select = mpc_src_t'(regs_reg[3][`MPC_B_SRC_HI:`MPC_B_SRC_LO]);
    end

    // output flops so analog lines never see decode glitches
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            left_gain_reg <= '0;
            right_gain_reg <= '0;
            ctrl_reg <= '0;
        end else begin
            left_gain_reg <= gain_dec[0];
            right_gain_reg <= gain_dec[1];
            ctrl_reg <= ctrl_next;
        end
    end

    assign monitor_left_gain = left_gain_reg;
    assign monitor_right_gain = right_gain_reg;
    assign playback_ctrl = ctrl_reg;

    // checks
    default clocking cb @(posedge aclk); endclocking

    sequence s_write_left(logic [6:0] v);
        wr_commit && wr_hit && wr_lane0 && wr_slot == 2'd0 && wr_data_eff[6:0] == v;
    endsequence
    sequence s_resp_ready;
        bvalid && bresp == `MPC_RESP_OKAY;
    endsequence

    reset_values_a: assert property (disable iff (1'b0) !aresetn |=>
        regs_reg[0] == `MPC_RST_GAIN && regs_reg[1] == `MPC_RST_GAIN
        && regs_reg[2] == `MPC_RST_PBO_A && regs_reg[3] == `MPC_RST_PBO_B)
        else $error("register reset values wrong");
    left_gain_write_a: assert property (disable iff (!aresetn)
        s_write_left(wr_data_eff[6:0]) |=> s_resp_ready ##0 regs_reg[0][6:0] == $past(wr_data_eff[6:0]))
        else $error("left gain write not stored");
    gain_range_a: assert property (disable iff (!aresetn)
        ##1 left_gain_reg.gain_valid == ($past(regs_reg[0][6:0]) <= `MPC_GAIN_MAX))
        else $error("gain range decode wrong");
    // the release edge still loads zero into the output flops, so it is kept out of the antecedents
    mute_code_a: assert property (disable iff (!aresetn)
        aresetn && (negative_attenuation_enable && regs_reg[1][6:0] == `MPC_GAIN_MUTE_NEG) |=> right_gain_reg.mute)
        else $error("attenuation mute code not muting");
    mute_plain_a: assert property (disable iff (!aresetn)
        aresetn && (!negative_attenuation_enable && regs_reg[0][6:0] == `MPC_GAIN_MUTE_POS) |=> left_gain_reg.mute)
        else $error("plain mute code not muting");
    mode_gate_a: assert property (disable iff (!aresetn)
        !regs_reg[2][`MPC_A_ENABLE] |=> !ctrl_reg.opamp_left_on && !ctrl_reg.preamp_on && !ctrl_reg.headphone_amp_on)
        else $error("controls active with mode disabled");
    opamp_follow_a: assert property (disable iff (!aresetn)
        ##1 ctrl_reg.opamp_left_on == $past(regs_reg[2][`MPC_A_ENABLE] && regs_reg[2][`MPC_A_OPAMP_L]))
        else $error("left opamp control wrong");
    // checked from the register bits, since the output flops read all zero during reset
    bypass_switch_a: assert property (disable iff (!aresetn)
        aresetn && (!regs_reg[3][`MPC_B_PUMP_ON] || !(regs_reg[2][`MPC_A_ENABLE] && regs_reg[3][`MPC_B_HPH_ON]))
        |=> ctrl_reg.bypass_switch_on)
        else $error("bypass not forced");
    source_hold_a: assert property (disable iff (!aresetn)
        (wr_commit && wr_hit && wr_lane0 && wr_slot == 2'd3 && wr_data_eff[1:0] == `MPC_SRC_RESERVED)
        |=> regs_reg[3][1:0] == $past(regs_reg[3][1:0]))
        else $error("reserved source code stored");
    reserved_zero_a: assert property (disable iff (!aresetn)
        rvalid |-> rdata[`MPC_DATA_W-1:`MPC_REG_W] == '0 && (regs_reg[2] & ~`MPC_MASK_PBO_A) == '0)
        else $error("undefined bits not zero");

endmodule : mpc_config_regs

// ==== mpc_params.svh ====
/*
 * constants for the monitor / playback-only configuration register bank:
 * register indices, byte addresses, field positions, reset values, codes.
 * assumes it is included by its bare name from the design files.
 */
`ifndef MPC_PARAMS_SVH
`define MPC_PARAMS_SVH

// bus geometry
`define MPC_ADDR_W 8
`define MPC_DATA_W 32
`define MPC_REG_W 8
`define MPC_NUM_REGS 4

// register indices as printed; byte address is four times the index
`define MPC_IDX_MON_LEFT 6'h0f
`define MPC_IDX_MON_RIGHT 6'h10
`define MPC_IDX_PBO_A 6'h11
`define MPC_IDX_PBO_B 6'h12
`define MPC_IDX_FIRST 6'h0f
`define MPC_IDX_LAST 6'h12

// reset values
`define MPC_RST_GAIN 8'h57
`define MPC_RST_PBO_A 8'h80
`define MPC_RST_PBO_B 8'h1b

// writable bit masks; all other bits read zero
`define MPC_MASK_GAIN 8'h7f
`define MPC_MASK_PBO_A 8'ha3
`define MPC_MASK_PBO_B 8'h7f

// playback_only_control_a fields
`define MPC_A_ENABLE 7
`define MPC_A_LINE_MUTE 5
`define MPC_A_OPAMP_L 1
`define MPC_A_OPAMP_R 0

// playback_only_control_b fields
`define MPC_B_HPH_ON 6
`define MPC_B_PUMP_BYP 5
`define MPC_B_REG_ON 4
`define MPC_B_PUMP_ON 3
`define MPC_B_PREAMP_ON 2
`define MPC_B_SRC_HI 1
`define MPC_B_SRC_LO 0

// gain codes
`define MPC_GAIN_MAX 7'h3e
`define MPC_GAIN_RESERVED 7'h3f
`define MPC_GAIN_MUTE_NEG 7'h57
`define MPC_GAIN_MUTE_POS 7'h7f

// headphone source code that software must not use
`define MPC_SRC_RESERVED 2'h2

// bus responses
`define MPC_RESP_OKAY 2'h0
`define MPC_RESP_SLVERR 2'h2

`endif

// ==== mpc_pkg.sv ====
/*
 * types for the monitor / playback-only configuration register bank.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package mpc_pkg;

    // decoded gain state for one microphone channel
    typedef struct packed {
        logic mute;          // channel muted
        logic gain_valid;    // code lies in the linear range
        logic [5:0] half_db; // gain in 0.5 dB steps
    } mpc_gain_t;

    // headphone source codes
    typedef enum logic [1:0] {
        MPC_SRC_PREAMP = 2'b00,
        MPC_SRC_OPAMP = 2'b01,
        MPC_SRC_RSVD = 2'b10,
        MPC_SRC_LINE = 2'b11
    } mpc_src_t;

    // analog control lines for playback-only mode
    typedef struct packed {
        logic mode_enable;
        logic line_input_mute;
        logic opamp_left_on;
        logic opamp_right_on;
        logic headphone_amp_on;
        logic bypass_switch_on;
        logic pump_auto_bypass_enable;
        logic mic_regulator_on;
        logic mic_pump_on;
        logic preamp_on;
        mpc_src_t source_select;
    } mpc_pbo_ctrl_t;

    // write channel states
    typedef enum logic [1:0] {
        MPC_WR_IDLE = 2'b00,
        MPC_WR_ADDR = 2'b01,
        MPC_WR_DATA = 2'b10,
        MPC_WR_RESP = 2'b11
    } mpc_wr_state_t;

endpackage : mpc_pkg

// ==== mpc_gain_decode.sv ====
/*
 * decodes a 7-bit monitor microphone gain code into a gain step and mute.
 * assumes the code comes from a register and the enable is a steady level.
 */
`timescale 1ns/1ps
`include "mpc_params.svh"

module mpc_gain_decode
    import mpc_pkg::*;
(
    // code in
    input wire logic [6:0] gain_code,
    input wire logic negative_attenuation_enable,
    // decoded result
    output mpc_gain_t gain
);

    // linear range covers codes 0 .. 62 at 0.5 dB each
    wire in_range = (gain_code <= `MPC_GAIN_MAX);
    // the two mute codes depend on the attenuation enable
    wire mute_neg = negative_attenuation_enable && (gain_code == `MPC_GAIN_MUTE_NEG);
    wire mute_pos = !negative_attenuation_enable && (gain_code == `MPC_GAIN_MUTE_POS);

    assign gain.mute = mute_neg | mute_pos;
    assign gain.gain_valid = in_range;
    // out-of-range codes drive the lowest step so the amplifier never sees junk
    assign gain.half_db = in_range ? gain_code[5:0] : 6'h00;

endmodule : mpc_gain_decode

// ==== tb_mpc.sv ====
/*
 * self-checking bench for the monitor gain / playback-only register bank.
 * assumes mpc_pkg compiled first and mpc_params.svh on the include path.
 */
`timescale 1ns/1ps
`include "mpc_params.svh"

module tb
    import mpc_pkg::*;
;
    // bus and side signals driven by the bench
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, nae;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    // design answers
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    mpc_gain_t gl, gr;
    mpc_pbo_ctrl_t pc;
    // reference register image and scoreboard
    logic [7:0] exp_reg [4];
    int fails, n_checks;
    logic [1:0] resp;
    logic [31:0] rd;

    mpc_config_regs i_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .negative_attenuation_enable(nae),
        .monitor_left_gain(gl), .monitor_right_gain(gr), .playback_ctrl(pc));

    // 200 mhz clock
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // verdict and end of run, reached from the main sequence and from timeouts
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : end_sim

    // single comparison point, four-state exact
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // a wait that ran out of cycles counts as a mismatch and ends the run
    task automatic hang(input string nm);
        fails++;
        $display("BAD %s expected handshake seen none", nm);
        end_sim();
    endtask : hang

    // axi4-lite write: address and data offered together, each dropped when taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                          output logic [1:0] r);
        int k;
        bit ta, tw, da, dw, tb_;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr <= a;
        wvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        bready <= 1'b1;
        da = 0;
        dw = 0;
        for (k = 0; k < 40 && !(da && dw); k++) begin
            @(negedge aclk);
            ta = (awready === 1'b1) && !da;
            tw = (wready === 1'b1) && !dw;
            @(posedge aclk);
            if (ta) begin
                awvalid <= 1'b0;
                da = 1;
            end
            if (tw) begin
                wvalid <= 1'b0;
                dw = 1;
            end
        end
        if (!(da && dw)) hang("aw_w");
        tb_ = 0;
        for (k = 0; k < 40 && !tb_; k++) begin
            @(negedge aclk);
            tb_ = (bvalid === 1'b1);
            r = bresp;
            @(posedge aclk);
            if (tb_) bready <= 1'b0;
        end
        if (!tb_) hang("bvalid");
    endtask : axi_wr

    // axi4-lite read: rready held until rvalid is sampled
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int k;
        bit t;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        t = 0;
        for (k = 0; k < 40 && !t; k++) begin
            @(negedge aclk);
            t = (arready === 1'b1);
            @(posedge aclk);
            if (t) arvalid <= 1'b0;
        end
        if (!t) hang("ar");
        t = 0;
        for (k = 0; k < 40 && !t; k++) begin
            @(negedge aclk);
            t = (rvalid === 1'b1);
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (t) rready <= 1'b0;
        end
        if (!t) hang("rvalid");
    endtask : axi_rd

    // byte address of register i, four times its index
    function automatic logic [7:0] adr(input int i);
        return 8'((`MPC_IDX_FIRST + i) * 4);
    endfunction : adr

    // reference gain decode; one mute reading, picked by the attenuation enable, used for both channels
    function automatic mpc_gain_t exp_gain(input logic [7:0] c, input logic e);
        mpc_gain_t g;
        g.mute = e ? (c[6:0] == `MPC_GAIN_MUTE_NEG) : (c[6:0] == `MPC_GAIN_MUTE_POS);
        g.gain_valid = (c[6:0] <= `MPC_GAIN_MAX);
        g.half_db = g.gain_valid ? c[5:0] : 6'h00;
        return g;
    endfunction : exp_gain

    // reference playback controls, gated by the mode enable bit except pump, pump auto bypass and source select
    function automatic mpc_pbo_ctrl_t exp_ctrl(input logic [7:0] a, input logic [7:0] b);
        mpc_pbo_ctrl_t c;
        logic en;
        en = a[`MPC_A_ENABLE];
        c.mode_enable = en;
        c.line_input_mute = en & a[`MPC_A_LINE_MUTE];
        c.opamp_left_on = en & a[`MPC_A_OPAMP_L];
        c.opamp_right_on = en & a[`MPC_A_OPAMP_R];
        c.headphone_amp_on = en & b[`MPC_B_HPH_ON];
        c.bypass_switch_on = !(en & b[`MPC_B_HPH_ON]) | !b[`MPC_B_PUMP_ON];
        c.pump_auto_bypass_enable = b[`MPC_B_PUMP_BYP];
        c.mic_regulator_on = en & b[`MPC_B_REG_ON];
        c.mic_pump_on = b[`MPC_B_PUMP_ON];
        c.preamp_on = en & b[`MPC_B_PREAMP_ON];
        c.source_select = mpc_src_t'(b[1:0]);
        return c;
    endfunction : exp_ctrl

    // reference write: masks, lane 0 strobe, reserved source code keeps old field
    function automatic void model_wr(input int i, input logic [31:0] d, input logic [3:0] s);
        logic [7:0] m;
        m = (i < 2) ? `MPC_MASK_GAIN : (i == 2) ? `MPC_MASK_PBO_A : `MPC_MASK_PBO_B;
        if (!s[0]) return;
        if (i == 3 && d[1:0] == `MPC_SRC_RESERVED) begin
            exp_reg[i] = (d[7:0] & m & 8'hfc) | (exp_reg[i] & 8'h03);
        end else begin
            exp_reg[i] = d[7:0] & m;
        end
    endfunction : model_wr

    // write one register and keep the reference in step
    task automatic wr_reg(input int i, input logic [31:0] d, input logic [3:0] s);
        axi_wr(adr(i), d, s, resp);
        model_wr(i, d, s);
        chk("bresp", 32'(resp), 32'(`MPC_RESP_OKAY));
    endtask : wr_reg

    // read back every register, then compare the decoded analog side
    task automatic chk_all();
        for (int i = 0; i < 4; i++) begin
            axi_rd(adr(i), rd, resp);
            chk("rdata", rd, {24'h0, exp_reg[i]});
            chk("rresp", 32'(resp), 32'(`MPC_RESP_OKAY));
        end
        // look between edges, where the registered outputs have settled
        @(negedge aclk);
        chk("left_gain", 32'(gl), 32'(exp_gain(exp_reg[0], nae)));
        chk("right_gain", 32'(gr), 32'(exp_gain(exp_reg[1], nae)));
        chk("ctrl", 32'(pc), 32'(exp_ctrl(exp_reg[2], exp_reg[3])));
    endtask : chk_all

    // bench reset, held n cycles, reference back to reset values
    task automatic do_reset(input int n);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (n) @(posedge aclk);
        aresetn <= 1'b1;
        exp_reg = '{`MPC_RST_GAIN, `MPC_RST_GAIN, `MPC_RST_PBO_A, `MPC_RST_PBO_B};
        repeat (2) @(posedge aclk);
        // idle bus after reset: all readies up, no response pending
        @(negedge aclk);
        chk("idle_bus", 32'({awready, wready, arready, bvalid, rvalid}), 32'h1c);
    endtask : do_reset

    // main sequence
    initial begin
        logic [31:0] d;
        logic [7:0] codes [6];
        logic [7:0] bad [4];
        aresetn = 1'b0;
        {awvalid, wvalid, bready, arvalid, rready, nae} = '0;
        {awaddr, araddr, wdata, wstrb} = '0;
        fails = 0;
        n_checks = 0;
        codes = '{8'h00, 8'h01, 8'h3e, 8'h40, 8'h57, 8'h7f};
        bad = '{8'h00, 8'h38, 8'h4c, 8'h3d};
        void'($urandom(93100));
        do_reset(12);
        chk_all();
        $display("test reset_values done");
        // random traffic over all registers and strobes
        repeat (40) begin
            d = $urandom();
            if (d[6:0] == `MPC_GAIN_RESERVED) d[0] = 1'b0;
            nae <= 1'($urandom());
            wr_reg(int'($urandom() % 4), d, 4'($urandom()));
            chk_all();
        end
        $display("test random done");
        // gain boundary and mute codes under both attenuation settings
        for (int e = 0; e < 2; e++) begin
            nae <= 1'(e);
            foreach (codes[k]) begin
                wr_reg(0, {24'hffffff, codes[k]}, 4'h1);
                wr_reg(1, {24'h0, codes[5 - k]}, 4'hf);
                chk_all();
            end
        end
        $display("test gain_codes done");
        // mode gating, pump-forced bypass, every source code with the reserved one last
        wr_reg(2, 32'h00, 4'h1);
        wr_reg(3, 32'h7f, 4'h1);
        chk_all();
        wr_reg(2, 32'hff, 4'h1);
        for (int s = 0; s < 4; s++) begin
            wr_reg(3, 32'(8'h44 | 2'(s + 3)), 4'h1);
            chk_all();
        end
        wr_reg(3, 32'h4d, 4'h1);
        chk_all();
        $display("test controls done");
        // unmapped and unaligned places answer with an error and store nothing
        foreach (bad[k]) begin
            axi_rd(bad[k], rd, resp);
            chk("bad_rdata", rd, 32'h0);
            chk("bad_rresp", 32'(resp), 32'(`MPC_RESP_SLVERR));
            axi_wr(bad[k], 32'hffffffff, 4'hf, resp);
            chk("bad_bresp", 32'(resp), 32'(`MPC_RESP_SLVERR));
        end
        wr_reg(0, 32'h12, 4'he);
        chk_all();
        $display("test refusals done");
        // reset in mid-run restores the reset image
        wr_reg(3, 32'h00, 4'h1);
        do_reset(3);
        chk_all();
        $display("test second_reset done");
        end_sim();
    end

    // overall guard against a stuck run
    initial begin
        #400000;
        hang("run_time");
    end

endmodule : tb
